// >>> src/gdfc_regs.sv
// Function
// [R1] fault clear write or long enable-low pulse zeroes all fault status
// [R2] phase-c status: drain oc high bit 7, low bit 6, gate fault 5, 4
// [R3] shunt oc channels 1,2,3 in bits 2,1,0; bit 3 reads zero
// [R4] supply, rail, regulator, pump, thermal disable bits make fault report-only
// [R5] thermal warning drives pin and summary only when routing bit set
// [R6] shunt oc response: latch, retry, report only, or off
// [R7] drain oc response uses the same four-way encoding
// [R8] latched overcurrent shutdown released only by clear or enable-low recovery
// [R9] gate fault disable and per-channel shunt disables stop detection
// [R10] fault clear clears every flag and reads back zero by itself
// [R11] lock code 110 blocks writes except lock field; 011 unlocks
// [R12] drive mode bit selects independent or pwm input mode
// [R13] three-bit shunt threshold code applies to all channels
// [R14] two-bit dead-time code stored and driven out
// [R15] two-bit gate transition limit code stored and driven out
// [R16] four amplifier enable bits, reset to zero
// [R17] high and low side four-bit drive strength codes
// [R18] four-bit drain oc threshold code
// [R19] retry wait 4000 us when bit zero, 70 us when one
// [R20] shared deglitch filter 1.57, 2.38, 3.49 or 5.73 us
// [R21] summary bit is the or of all fault flags, thermal warning only when routed
// [R22] control registers return to defaults on entering sleep
// [R23] phase-a gate input select fields stored and driven out
// [R24] flags stay set until cleared; reads work while locked
// [R25] writes to status registers are ignored
`timescale 1ns/1ps
`default_nettype none
`include "gdfc_params.svh"

module gdfc_regs
  import gdfc_pkg::*;
#(
  parameter int TSLEEP_CYC      = `GDFC_CYC(`GDFC_TSLEEP_NS),
  parameter int RETRY_LONG_CYC  = `GDFC_CYC(`GDFC_RETRY_LONG_NS),
  parameter int RETRY_SHORT_CYC = `GDFC_CYC(`GDFC_RETRY_SHORT_NS)
) (
  input  wire logic        sys_clk_i,            // system clock
  input  wire logic        rst_i,                // async reset, high
  input  wire logic        en_i,                 // enable pin, async
  input  wire logic        spi_sclk_i,           // serial clock, async
  input  wire logic        spi_cs_n_i,           // chip select, low
  input  wire logic        spi_mosi_i,           // serial data in
  output logic             spi_miso_o,           // serial data out
  input  wire gdfc_fault_s fault_i,              // raw detector levels
  output logic             fault_output_pin_n_o, // fault pin, low
  output gdfc_ctrl_s       ctrl_o,               // control fields
  output logic             drain_oc_shutdown_o,  // drain oc gate stop
  output logic             shunt_oc_shutdown_o,  // shunt oc gate stop
  output logic             supply_shutdown_o,    // supply fault stop
  output logic             sleep_o               // sleep entered
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------

  // reset image of the whole state; sleep reloads its control fields
  function automatic gdfc_state_s rst_state();
    gdfc_state_s s;
    s           = '0;
    s.csn_sync  = 2'h3;
    s.ctl1      = `GDFC_RST_CTL1;
    s.ctl2      = `GDFC_RST_CTL2;
    s.ctrl.ic1  = `GDFC_RST_IC1;
    s.ctrl.ic2  = `GDFC_RST_IC2;
    s.ctrl.drv  = `GDFC_RST_DRV;
    s.ctrl.ocp  = `GDFC_RST_OCP;
    s.ctrl.sela = `GDFC_RST_SELA;
    s.fault_n   = 1'b1;
    return s;
  endfunction

  localparam gdfc_state_s ST_RST = rst_state();

  // deglitch length in cycles for a code
  function automatic logic [9:0] dgl_cycles(input logic [1:0] code);
    case (code)
      2'h0:    return 10'(`GDFC_CYC(`GDFC_DGL0_NS));
      2'h1:    return 10'(`GDFC_CYC(`GDFC_DGL1_NS));
      2'h2:    return 10'(`GDFC_CYC(`GDFC_DGL2_NS));
      default: return 10'(`GDFC_CYC(`GDFC_DGL3_NS));
    endcase
  endfunction

  // retry wait in cycles for a select bit
  function automatic logic [19:0] retry_cycles(input logic sel);
    return sel ? 20'(RETRY_SHORT_CYC) : 20'(RETRY_LONG_CYC); // [R19]
  endfunction

  // summary: warning counts only when routed
  function automatic logic flag_summary(input gdfc_fault_s f, input logic route);
    gdfc_fault_s t;
    t              = f;
    t.thermal_warn = f.thermal_warn & route; // [R5]
    return |t;                               // [R21]
  endfunction

  // read decode; status built from the sticky flags
  function automatic logic [7:0] reg_read(input logic [6:0] a, input gdfc_state_s s);
    gdfc_fault_s f;
    f = s.flags;
    case (a)
      `GDFC_OFS_STS0: return {flag_summary(f, s.ctl1.thermal_warning_routing),
                              f.drive_rail_uv | f.drive_rail_ov | f.regulator_oc,
                              f.pump_uv | f.supply_uv | f.supply_ov,
                              |{f.drain_hi, f.drain_lo},
                              |{f.gate_hi, f.gate_lo},
                              |f.shunt, f.thermal_sd, f.thermal_warn};
      `GDFC_OFS_STS1: return {f.drive_rail_uv, f.drive_rail_ov, f.regulator_oc,
                              f.pump_uv, f.supply_uv, f.supply_ov, 2'h0};
      `GDFC_OFS_STS2: return {f.drain_hi[0], f.drain_lo[0], f.gate_hi[0], f.gate_lo[0],
                              f.drain_hi[1], f.drain_lo[1], f.gate_hi[1], f.gate_lo[1]};
      `GDFC_OFS_STS3: return {f.drain_hi[2], f.drain_lo[2],      // [R2]
                              f.gate_hi[2], f.gate_lo[2], 1'b0,  // [R3]
                              f.shunt[0], f.shunt[1], f.shunt[2]};
      `GDFC_OFS_CTL1: return s.ctl1;
      `GDFC_OFS_CTL2: return s.ctl2;
      `GDFC_OFS_IC1:  return s.ctrl.ic1; // clear bit is never stored
      `GDFC_OFS_IC2:  return s.ctrl.ic2;
      `GDFC_OFS_DRV:  return s.ctrl.drv;
      `GDFC_OFS_OCP:  return s.ctrl.ocp;
      `GDFC_OFS_SELA: return s.ctrl.sela;
      default:        return 8'h00;
    endcase
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------

  gdfc_state_s q;
  gdfc_state_s d;

  // ----------------------------------------
  // next state
  // ----------------------------------------

  // one process computes the whole next state
  always_comb begin
    logic        rise;
    logic        fall;
    logic        clr;
    logic        sleep_enter;
    logic        locked;
    logic [15:0] word;
    gdfc_ic1_s   wi;
    gdfc_fault_s f;
    gdfc_fault_s set;
    gdfc_fault_s nf;
    logic [5:0]  drain_raw;
    logic [2:0]  shunt_raw;
    logic [1:0]  mode;
    logic [1:0]  confirm;
    logic [1:0]  raw_any;
    logic [9:0]  lim;
    logic [19:0] rlim;
    rise        = 1'b0;
    fall        = 1'b0;
    clr         = 1'b0;
    sleep_enter = 1'b0;
    locked      = 1'b0;
    word        = 16'h0000;
    wi          = '0;
    f           = '0;
    set         = '0;
    nf          = '0;
    drain_raw   = 6'h00;
    shunt_raw   = 3'h0;
    mode        = 2'h0;
    confirm     = 2'h0;
    raw_any     = 2'h0;
    lim         = 10'h000;
    rlim        = 20'h00000;
    d           = q;

    // two-stage synchronisers for everything off-domain
    d.flt_s1       = fault_i;
    d.flt_s2       = q.flt_s1;
    d.en_sync[0]   = en_i;
    d.en_sync[1]   = q.en_sync[0];
    d.sclk_sync[0] = spi_sclk_i;
    d.sclk_sync[1] = q.sclk_sync[0];
    d.sclk_sync[2] = q.sclk_sync[1];
    d.csn_sync[0]  = spi_cs_n_i;
    d.csn_sync[1]  = q.csn_sync[0];
    d.mosi_sync[0] = spi_mosi_i;
    d.mosi_sync[1] = q.mosi_sync[0];
    f              = q.flt_s2;

    // enable-low timer; sleep entered once after the full time
    if (q.en_sync[1]) begin
      d.sleep_cnt = 20'h00000;
      d.sleep     = 1'b0;
    end else if (!q.sleep) begin
      if (q.sleep_cnt >= 20'(TSLEEP_CYC - 1)) begin
        sleep_enter = 1'b1;
        d.sleep     = 1'b1;
      end else begin
        d.sleep_cnt = q.sleep_cnt + 20'h00001;
      end
    end

    // serial slave: edges seen on the second sync stage only
    rise   = q.sclk_sync[1] & ~q.sclk_sync[2];
    fall   = ~q.sclk_sync[1] & q.sclk_sync[2];
    locked = (q.ctrl.ic1.write_lock == `GDFC_LOCK_SET);
    word   = {q.shift, q.mosi_sync[1]};
    wi     = word[7:0];
    if (q.csn_sync[1]) begin
      d.bit_cnt = 5'h00;
      d.miso    = 1'b0;
    end else if (rise && q.bit_cnt < `GDFC_FRAME_BITS) begin
      d.shift   = word[14:0];
      d.bit_cnt = q.bit_cnt + 5'h01;
      // header done: snapshot read data, allowed while locked
      if (q.bit_cnt == `GDFC_HDR_BITS - 5'h01 && word[7]) begin
        d.rd_sh = reg_read(word[6:0], q); // [R24]
      end
      // last bit of a write frame commits it
      if (q.bit_cnt == `GDFC_FRAME_BITS - 5'h01 && !word[15] && !q.sleep) begin
        if (locked) begin
          if (word[14:8] == `GDFC_OFS_IC1 &&
              (wi.write_lock == `GDFC_LOCK_SET || wi.write_lock == `GDFC_LOCK_CLR)) begin
            d.ctrl.ic1.write_lock = wi.write_lock; // [R11]
          end
        end else begin
          case (word[14:8])
            `GDFC_OFS_CTL1: d.ctl1 = word[7:0]; // [R4] [R5]
            `GDFC_OFS_CTL2: d.ctl2 = word[7:0]; // [R6] [R7] [R9]
            `GDFC_OFS_IC1: begin
              d.ctrl.ic1.drive_input_mode   = wi.drive_input_mode;   // [R12]
              d.ctrl.ic1.shunt_oc_threshold = wi.shunt_oc_threshold; // [R13]
              if (wi.write_lock == `GDFC_LOCK_SET || wi.write_lock == `GDFC_LOCK_CLR) begin
                d.ctrl.ic1.write_lock = wi.write_lock; // [R11]
              end
              clr = wi.fault_clear; // [R10]
            end
            `GDFC_OFS_IC2:  d.ctrl.ic2  = word[7:0]; // [R14] [R15] [R16]
            `GDFC_OFS_DRV:  d.ctrl.drv  = word[7:0]; // [R17]
            `GDFC_OFS_OCP:  d.ctrl.ocp  = word[7:0]; // [R18] [R19] [R20]
            `GDFC_OFS_SELA: d.ctrl.sela = word[7:0]; // [R23]
            default: ;                               // [R25]
          endcase
        end
      end
    end else if (fall && q.bit_cnt >= `GDFC_HDR_BITS && q.bit_cnt < `GDFC_FRAME_BITS) begin
      d.miso  = q.rd_sh[7];
      d.rd_sh = {q.rd_sh[6:0], 1'b0};
    end

    // enable-low recovery clears like a clear write
    clr = clr | sleep_enter; // [R1]

    // qualified overcurrent detector levels
    drain_raw = {f.drain_hi, f.drain_lo};
    shunt_raw = f.shunt & ~{q.ctl2.shunt3_oc_disable, q.ctl2.shunt2_oc_disable,
                            q.ctl2.shunt1_oc_disable}; // [R9]
    raw_any   = {|shunt_raw, |drain_raw};
    lim       = dgl_cycles(q.ctrl.ocp.oc_deglitch_time); // [R20]

    // group 0 drain, group 1 shunt: deglitch then respond
    for (int g = 0; g < 2; g++) begin
      mode = (g == 1) ? q.ctl2.shunt_oc_response : q.ctl2.drain_oc_response;
      rlim = retry_cycles((g == 1) ? q.ctrl.ocp.shunt_oc_retry_time
                                   : q.ctrl.ocp.drain_oc_retry_time);
      if (!raw_any[g] || mode == `GDFC_MODE_OFF) begin // [R6] [R7]
        d.dgl[g] = 10'h000;
      end else if (q.dgl[g] != lim) begin
        d.dgl[g] = q.dgl[g] + 10'h001;
        if (q.dgl[g] == lim - 10'h001) begin
          confirm[g] = 1'b1;
        end
      end
      case (q.oc[g])
        OC_IDLE: begin
          if (confirm[g] && mode == `GDFC_MODE_LATCH) begin
            d.oc[g] = OC_LATCHED; // [R6] [R7]
          end else if (confirm[g] && mode == `GDFC_MODE_RETRY) begin
            d.oc[g]    = OC_RETRY;
            d.retry[g] = 20'h00000;
          end
        end
        OC_LATCHED: begin
          if (clr) begin
            d.oc[g] = OC_IDLE; // [R8]
          end
        end
        OC_RETRY: begin
          if (clr || q.retry[g] >= rlim - 20'h00001) begin
            d.oc[g]  = OC_IDLE; // [R19]
            d.dgl[g] = 10'h000; // a lasting fault re-trips
          end else begin
            d.retry[g] = q.retry[g] + 20'h00001;
          end
        end
        default: d.oc[g] = OC_IDLE;
      endcase
    end

    // flag sources; overcurrent only after deglitch, mode not off
    if (confirm[0]) begin
      set.drain_hi = f.drain_hi; // [R2] [R7]
      set.drain_lo = f.drain_lo;
    end
    if (confirm[1]) begin
      set.shunt = shunt_raw; // [R3] [R6]
    end
    if (!q.ctl2.gate_fault_disable) begin
      set.gate_hi = f.gate_hi; // [R9]
      set.gate_lo = f.gate_lo;
    end
    set.drive_rail_uv = f.drive_rail_uv; // [R4]
    set.drive_rail_ov = f.drive_rail_ov;
    set.regulator_oc  = f.regulator_oc;
    set.pump_uv       = f.pump_uv;
    set.supply_uv     = f.supply_uv;
    set.supply_ov     = f.supply_ov;
    set.thermal_sd    = f.thermal_sd;
    set.thermal_warn  = f.thermal_warn; // [R5]

    // sticky flags: a new event wins over a clear in the same cycle
    nf        = (clr ? gdfc_fault_s'('0) : q.flags) | set; // [R1] [R10] [R24]
    d.flags   = nf;
    d.fault_n = ~flag_summary(nf, d.ctl1.thermal_warning_routing); // [R5] [R21]

    // supply and thermal shutdown faults stop the bridge unless report-only
    d.supply_stop = |({f.drive_rail_uv, f.drive_rail_ov, f.regulator_oc, f.pump_uv,
                       f.supply_uv, f.supply_ov, f.thermal_sd} &
                      ~{q.ctl1.drive_rail_uv_report_only, q.ctl1.drive_rail_ov_report_only,
                        q.ctl1.regulator_oc_report_only, q.ctl1.pump_uv_report_only,
                        q.ctl1.supply_uv_report_only, q.ctl1.supply_ov_report_only,
                        q.ctl1.thermal_shutdown_report_only}); // [R4]

    // sleep puts every control register back to its default
    if (sleep_enter || q.sleep) begin
      d.ctl1 = ST_RST.ctl1; // [R22]
      d.ctl2 = ST_RST.ctl2;
      d.ctrl = ST_RST.ctrl;
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------

  // whole state in one register
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= ST_RST;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------

  // all outputs come from state flops; the two oc stops decode the oc state
  assign spi_miso_o           = q.miso;
  assign fault_output_pin_n_o = q.fault_n;
  assign ctrl_o               = q.ctrl; // [R12] [R13] [R14] [R15] [R16] [R17] [R18] [R23]
  assign drain_oc_shutdown_o  = (q.oc[0] != OC_IDLE); // [R7] [R8]
  assign shunt_oc_shutdown_o  = (q.oc[1] != OC_IDLE); // [R6] [R8]
  assign supply_shutdown_o    = q.supply_stop;
  assign sleep_o              = q.sleep;

endmodule

`default_nettype wire

// >>> src/gdfc_params.svh
`ifndef GDFC_PARAMS_SVH
`define GDFC_PARAMS_SVH

// register offsets (7-bit frame address)
`define GDFC_OFS_STS0 7'h00
`define GDFC_OFS_STS1 7'h01
`define GDFC_OFS_STS2 7'h02
`define GDFC_OFS_STS3 7'h03
`define GDFC_OFS_CTL1 7'h04
`define GDFC_OFS_CTL2 7'h05
`define GDFC_OFS_IC1  7'h06
`define GDFC_OFS_IC2  7'h07
`define GDFC_OFS_DRV  7'h08
`define GDFC_OFS_OCP  7'h09
`define GDFC_OFS_SELA 7'h0a

// reset values
`define GDFC_RST_CTL1 8'h00
`define GDFC_RST_CTL2 8'h07
`define GDFC_RST_IC1  8'h35
`define GDFC_RST_IC2  8'h50
`define GDFC_RST_DRV  8'hff
`define GDFC_RST_OCP  8'h00
`define GDFC_RST_SELA 8'h14

// lock codes and overcurrent response codes
`define GDFC_LOCK_SET    3'h6
`define GDFC_LOCK_CLR    3'h3
`define GDFC_MODE_LATCH  2'h0
`define GDFC_MODE_RETRY  2'h1
`define GDFC_MODE_REPORT 2'h2
`define GDFC_MODE_OFF    2'h3

// frame layout: r/w bit, 7 address bits, 8 data bits
`define GDFC_HDR_BITS   5'h08
`define GDFC_FRAME_BITS 5'h10

// timing, least times round up
`define GDFC_CLK_NS          8
`define GDFC_CYC(ns)         (((ns) + `GDFC_CLK_NS - 1) / `GDFC_CLK_NS)
`define GDFC_TSLEEP_NS       850000
`define GDFC_RETRY_LONG_NS   4000000
`define GDFC_RETRY_SHORT_NS  70000
`define GDFC_DGL0_NS         1570
`define GDFC_DGL1_NS         2380
`define GDFC_DGL2_NS         3490
`define GDFC_DGL3_NS         5730

`endif

// >>> src/gdfc_pkg.sv
`default_nettype none
package gdfc_pkg;

  typedef enum logic [1:0] {OC_IDLE, OC_LATCHED, OC_RETRY} gdfc_oc_e;

  typedef struct packed {
    logic drive_rail_uv_report_only;
    logic drive_rail_ov_report_only;
    logic regulator_oc_report_only;
    logic pump_uv_report_only;
    logic supply_uv_report_only;
    logic supply_ov_report_only;
    logic thermal_shutdown_report_only;
    logic thermal_warning_routing;
  } gdfc_ctl1_s;

  typedef struct packed {
    logic [1:0] shunt_oc_response;
    logic [1:0] drain_oc_response;
    logic       gate_fault_disable;
    logic       shunt1_oc_disable;
    logic       shunt2_oc_disable;
    logic       shunt3_oc_disable;
  } gdfc_ctl2_s;

  typedef struct packed {
    logic       fault_clear;
    logic [2:0] write_lock;
    logic       drive_input_mode;
    logic [2:0] shunt_oc_threshold;
  } gdfc_ic1_s;

  typedef struct packed {
    logic [1:0] dead_time;
    logic [1:0] gate_transition_limit;
    logic       back_emf_amp_enable;
    logic       amp1_enable;
    logic       amp2_enable;
    logic       amp3_enable;
  } gdfc_ic2_s;

  typedef struct packed {
    logic [3:0] high_side_drive_strength;
    logic [3:0] low_side_drive_strength;
  } gdfc_drv_s;

  typedef struct packed {
    logic [3:0] drain_oc_threshold;
    logic       shunt_oc_retry_time;
    logic       drain_oc_retry_time;
    logic [1:0] oc_deglitch_time;
  } gdfc_ocp_s;

  typedef struct packed {
    logic       cmp1_hysteresis;
    logic [2:0] phase_a_high_input_select;
    logic       supply_uv_threshold;
    logic [2:0] phase_a_low_input_select;
  } gdfc_sela_s;

  // control fields driven out to the analog side
  typedef struct packed {
    gdfc_ic1_s  ic1;
    gdfc_ic2_s  ic2;
    gdfc_drv_s  drv;
    gdfc_ocp_s  ocp;
    gdfc_sela_s sela;
  } gdfc_ctrl_s;

  // detector levels and sticky flags; index 0 = phase a / channel 1
  typedef struct packed {
    logic [2:0] drain_hi;
    logic [2:0] drain_lo;
    logic [2:0] gate_hi;
    logic [2:0] gate_lo;
    logic [2:0] shunt;
    logic       drive_rail_uv;
    logic       drive_rail_ov;
    logic       regulator_oc;
    logic       pump_uv;
    logic       supply_uv;
    logic       supply_ov;
    logic       thermal_sd;
    logic       thermal_warn;
  } gdfc_fault_s;

  typedef struct packed {
    gdfc_fault_s          flt_s1;
    gdfc_fault_s          flt_s2;
    logic [1:0]           en_sync;
    logic [2:0]           sclk_sync;
    logic [1:0]           csn_sync;
    logic [1:0]           mosi_sync;
    logic [19:0]          sleep_cnt;
    logic                 sleep;
    logic [4:0]           bit_cnt;
    logic [14:0]          shift;
    logic [7:0]           rd_sh;
    logic                 miso;
    gdfc_ctl1_s           ctl1;
    gdfc_ctl2_s           ctl2;
    gdfc_ctrl_s           ctrl;
    gdfc_fault_s          flags;
    gdfc_oc_e [1:0]       oc;
    logic [1:0][9:0]      dgl;
    logic [1:0][19:0]     retry;
    logic                 fault_n;
    logic                 supply_stop;
  } gdfc_state_s;

endpackage
`default_nettype wire

// >>> sim/gdfc_regs_checker.sv
`timescale 1ns/1ps
`default_nettype none

module gdfc_regs_checker
  import gdfc_pkg::*;
#(
  parameter int TSLEEP_CYC = 106250
) (
  input wire logic        sys_clk_i,            // clock
  input wire logic        rst_i,                // reset
  input wire logic        en_i,                 // enable pin
  input wire gdfc_fault_s fault_i,              // raw faults
  input wire logic        fault_output_pin_n_o, // fault pin
  input wire gdfc_ctrl_s  ctrl_o,               // controls
  input wire logic        drain_oc_shutdown_o,  // drain stop
  input wire logic        shunt_oc_shutdown_o,  // shunt stop
  input wire logic        sleep_o               // asleep
);
  localparam gdfc_ctrl_s DEF = 40'h3550ff0014;
  logic [19:0] low_q;
  logic [19:0] sh_q;
  logic [19:0] dr_q;

  // raw run lengths, saturating so a long fault never wraps
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      low_q <= '0;
      sh_q  <= '0;
      dr_q  <= '0;
    end else begin
      low_q <= en_i ? '0 : low_q + {19'h0, ~&low_q};
      sh_q  <= ~|fault_i.shunt ? '0 : sh_q + {19'h0, ~&sh_q};
      dr_q  <= ~|{fault_i.drain_hi, fault_i.drain_lo} ? '0 : dr_q + {19'h0, ~&dr_q};
    end
  end

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);

  a_clear_self_zero: assert property (ctrl_o.ic1.fault_clear == 1'b0)
    else $error("fault clear bit seen high");
  a_reset_defaults: assert property ($fell(rst_i) |-> ctrl_o == DEF)
    else $error("controls not at defaults after reset");
  a_sleep_defaults: assert property (sleep_o && $past(sleep_o) |-> ctrl_o == DEF)
    else $error("controls not at defaults in sleep");
  a_sleep_not_early: assert property ($rose(sleep_o) |-> low_q >= 20'(TSLEEP_CYC))
    else $error("sleep entered too soon");
  a_sleep_in_time: assert property (low_q == 20'(TSLEEP_CYC + 8) |-> sleep_o)
    else $error("sleep not entered");
  a_shunt_deglitch: assert property ($rose(shunt_oc_shutdown_o) |-> sh_q >= 20'd197)
    else $error("shunt stop before deglitch");
  a_drain_deglitch: assert property ($rose(drain_oc_shutdown_o) |-> dr_q >= 20'd197)
    else $error("drain stop before deglitch");
  a_shunt_pin_low: assert property (shunt_oc_shutdown_o && $past(shunt_oc_shutdown_o, 2)
    |-> !fault_output_pin_n_o)
    else $error("shunt stop without fault pin");
  a_drain_pin_low: assert property (drain_oc_shutdown_o && $past(drain_oc_shutdown_o, 2)
    |-> !fault_output_pin_n_o)
    else $error("drain stop without fault pin");
endmodule

bind gdfc_regs gdfc_regs_checker #(.TSLEEP_CYC(TSLEEP_CYC)) chk_u (
  .sys_clk_i(sys_clk_i),
  .rst_i(rst_i),
  .en_i(en_i),
  .fault_i(fault_i),
  .fault_output_pin_n_o(fault_output_pin_n_o),
  .ctrl_o(ctrl_o),
  .drain_oc_shutdown_o(drain_oc_shutdown_o),
  .shunt_oc_shutdown_o(shunt_oc_shutdown_o),
  .sleep_o(sleep_o)
);

`default_nettype wire

// >>> sim/gdfc_spi_master.sv
`timescale 1ns/1ps
`default_nettype none

module gdfc_spi_master (
  input  wire logic spi_miso_i, // data from block
  output logic      spi_sclk_o, // link clock, still between frames
  output logic      spi_cs_n_o, // select, low
  output logic      spi_mosi_o  // data to block
);
  initial begin
    spi_sclk_o = 1'b0;
    spi_cs_n_o = 1'b1;
    spi_mosi_o = 1'b0;
  end

  // one whole 16-bit frame, msb first, 125 ns link period; data changes
  // only while the clock is low so each rise sees settled data
  task automatic xfer(input logic rd, input logic [6:0] adr, input logic [7:0] wd,
                      output logic [7:0] rdat);
    logic [15:0] fr;
    fr = {rd, adr, wd};
    rdat = 8'h00;
    spi_cs_n_o = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      spi_mosi_o = fr[i];
      #62.5;
      if (i < 8) rdat = {rdat[6:0], spi_miso_i};
      spi_sclk_o = 1'b1;
      #62.5;
      spi_sclk_o = 1'b0;
    end
    #62.5;
    spi_cs_n_o = 1'b1;
    spi_mosi_o = ~spi_mosi_o; // released line keeps no stale bit
    #200;
  endtask
endmodule

`default_nettype wire

// >>> sim/gdfc_regs_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) \
  begin \
    num_checks++; \
    if ((g) !== (e)) begin \
      error_cnt++; \
      $display("mismatch at %0t: got %h expected %h", $time, g, e); \
    end \
  end

module gdfc_regs_test;
  import gdfc_pkg::*;
  localparam int TS = 40;
  localparam logic [7:0] RST [8] = '{8'h00, 8'h00, 8'h07, 8'h35, 8'h50, 8'hff, 8'h00, 8'h14};
  localparam logic [7:0] W [8] = '{8'hff, 8'ha5, 8'h5a, 8'h3a, 8'hc3, 8'h0f, 8'hf0, 8'he7};
  logic        sys_clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        en_i = 1'b1;
  gdfc_fault_s flt = '0;
  wire logic   sclk, cs_n, mosi, miso;
  logic        pin_n, dsd, ssd, psd, slp;
  gdfc_ctrl_s  ctrl;
  int          error_cnt = 0;
  int          num_checks = 0;

  always #4 sys_clk_i = ~sys_clk_i;

  gdfc_regs #(.TSLEEP_CYC(TS), .RETRY_LONG_CYC(60), .RETRY_SHORT_CYC(20)) dut_u (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .en_i(en_i), .spi_sclk_i(sclk),
    .spi_cs_n_i(cs_n), .spi_mosi_i(mosi), .spi_miso_o(miso), .fault_i(flt),
    .fault_output_pin_n_o(pin_n), .ctrl_o(ctrl), .drain_oc_shutdown_o(dsd),
    .shunt_oc_shutdown_o(ssd), .supply_shutdown_o(psd), .sleep_o(slp));
  gdfc_spi_master mst_u (.spi_miso_i(miso), .spi_sclk_o(sclk), .spi_cs_n_o(cs_n),
    .spi_mosi_o(mosi));

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask
  // each frame ends on a clock edge plus the stimulus delay
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] unused;
    mst_u.xfer(1'b0, a, d, unused);
    cyc(1);
  endtask
  task automatic rd_chk(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] got;
    mst_u.xfer(1'b1, a, 8'h00, got);
    `CHK(got, e)
    cyc(1);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // hang guard: the tests need about 200 us, so 500 us means a hang
  initial begin
    #500000;
    error_cnt++;
    tally_and_finish();
  end

  initial begin
    repeat (2) @(posedge sys_clk_i);
    #1 rst_i = 1'b0;
    // defaults, write and read back, status and unmapped places ignore writes
    for (int i = 0; i < 8; i++) rd_chk(7'h03 + 7'(i), RST[i]);
    for (int i = 0; i < 8; i++) wr(7'h03 + 7'(i), W[i]);
    for (int i = 0; i < 8; i++) rd_chk(7'h03 + 7'(i), i == 0 ? 8'h00 : W[i]);
    wr(7'h20, 8'hff);
    rd_chk(7'h20, 8'h00);
    `CHK(ctrl, {W[3], W[4], W[5], W[6], W[7]})
    // odd lock code does nothing, lock blocks writes but not reads
    wr(7'h06, 8'h52);
    rd_chk(7'h06, 8'h32);
    wr(7'h06, 8'h62);
    wr(7'h07, 8'hff);
    rd_chk(7'h07, W[4]);
    wr(7'h06, 8'h30);
    wr(7'h07, 8'h00);
    rd_chk(7'h07, 8'h00);
    // latched faults on phase c and channel 1, then clear
    wr(7'h05, 8'h00);
    wr(7'h09, 8'h00);
    flt.shunt = 3'b001;
    flt.drain_hi = 3'b100;
    flt.gate_hi = 3'b100;
    cyc(250);
    flt = '0;
    cyc(20);
    `CHK({ssd, dsd, pin_n}, 3'b110)
    rd_chk(7'h03, 8'ha4);
    rd_chk(7'h00, 8'h9c);
    wr(7'h06, 8'hb0);
    rd_chk(7'h06, 8'h30);
    rd_chk(7'h03, 8'h00);
    `CHK({ssd, dsd, pin_n}, 3'b001)
    // every response code, channels 1 and 2 and gate faults disabled
    for (int m = 0; m < 4; m++) begin
      wr(7'h05, {2'(m), 2'(m), 4'he});
      flt.shunt = 3'b111;
      flt.drain_lo = 3'b100;
      flt.gate_lo = 3'b100;
      cyc(250);
      `CHK({ssd, dsd, pin_n}, {m < 2, m < 2, m == 3})
      flt = '0;
      cyc(80);
      `CHK({ssd, dsd}, {m == 0, m == 0})
      rd_chk(7'h03, m == 3 ? 8'h00 : 8'h41);
      wr(7'h06, 8'hb0);
    end
    // slowest deglitch code and short drain retry on phase a high side
    wr(7'h05, 8'h10);
    wr(7'h09, 8'h07);
    flt.drain_hi = 3'b001;
    cyc(600);
    `CHK(dsd, 1'b0)
    cyc(130);
    `CHK(dsd, 1'b1)
    flt = '0;
    cyc(30);
    `CHK(dsd, 1'b0)
    wr(7'h06, 8'hb0);
    // thermal warning routed and not routed
    wr(7'h04, 8'h00);
    flt.thermal_warn = 1'b1;
    cyc(10);
    `CHK(pin_n, 1'b1)
    wr(7'h04, 8'h01);
    `CHK(pin_n, 1'b0)
    rd_chk(7'h00, 8'h81);
    flt = '0;
    wr(7'h04, 8'h00);
    rd_chk(7'h00, 8'h01);
    `CHK(pin_n, 1'b1)
    wr(7'h06, 8'hb0);
    // each supply or thermal shutdown fault stops the driver unless made report-only
    for (int b = 1; b < 8; b++) begin
      flt = '0;
      flt[b] = 1'b1;
      cyc(8);
      `CHK(psd, 1'b1)
      wr(7'h04, 8'h01 << b);
      `CHK(psd, 1'b0)
      wr(7'h04, 8'h00);
    end
    flt = '0;
    rd_chk(7'h01, 8'hfc);
    // long enable-low pulse restores defaults and clears flags
    wr(7'h07, 8'h0f);
    en_i = 1'b0;
    cyc(TS + 10);
    `CHK(slp, 1'b1)
    en_i = 1'b1;
    cyc(10);
    rd_chk(7'h07, 8'h50);
    rd_chk(7'h01, 8'h00);
    tally_and_finish();
  end
endmodule

`undef CHK
`default_nettype wire
